// ===== bench/adc_acquisition_control_props.sv
`timescale 1ns/1ns
module adc_acquisition_control_props
  import adc_acq_pkg::*;
(
  input wire logic i_clock, // Clock.
  input wire logic i_nrst, // Reset, low.
  input wire logic i_ce, // Enable.
  input wire logic [3:0] i_addr, // Offset.
  input wire logic i_rd, // Read.
  input wire logic i_wr, // Write.
  input wire logic i_word, // Word access.
  input wire logic [15:0] i_wdata, // Write data.
  input wire logic [15:0] o_rdata, // Read data.
  input wire logic [3:0] o_digital_out_bit, // Outputs.
  input wire logic o_counter_zero_clock_select, // Clock select.
  input wire logic o_tick_1mhz, // Tick.
  input wire logic o_convert_start, // Start.
  input wire logic o_sample_stored, // FIFO write.
  input wire logic [3:0] o_irq_level_select, // Line.
  input wire logic o_irq // Request.
);
  logic sw_reg;
  logic bw;
  // Byte writes only; word writes elsewhere are refused.
  assign bw = i_ce && i_wr && !i_word;
  // Starts and interrupts depend on the mode, so it is tracked here.
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) sw_reg <= 1'b1;
    else if (bw && i_addr == OFS_IRQ_PACER) sw_reg <= !i_wdata[1];
  end
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_nrst);
  AST_LEVEL_CODE: assert property (!(o_irq_level_select inside {4'h1, 4'h8, 4'h9, 4'hd}))
    else $error("Unavailable line selected");
  AST_LEVEL_OFF: assert property (o_irq_level_select == 4'h0 |-> !o_irq)
    else $error("Request with no line");
  AST_RDATA_HOLD: assert property (!(i_ce && i_rd) |=> $stable(o_rdata))
    else $error("Read data moved");
  AST_PORT_OUT: assert property (bw && i_addr == OFS_PORT |=> o_digital_out_bit == $past(i_wdata[3:0]))
    else $error("Outputs not latched");
  AST_CLK_SEL: assert property (bw && i_addr == OFS_BURST |=> o_counter_zero_clock_select == $past(i_wdata[1]))
    else $error("Clock select wrong");
  AST_IRQ_CLEAR: assert property (bw && i_addr == OFS_STATUS && !o_sample_stored && !$past(o_sample_stored)
    |=> !o_irq) else $error("Request not cleared");
  AST_SW_IRQ: assert property (sw_reg && o_sample_stored && o_irq_level_select != 4'h0 |=> o_irq)
    else $error("No request per sample");
  AST_SW_START: assert property (sw_reg && i_ce && i_wr && i_word && i_addr == OFS_DATA
    |-> ##[1:400] o_convert_start) else $error("Start late");
  AST_TICK_GAP: assert property (o_tick_1mhz |-> ##125 o_tick_1mhz)
    else $error("Tick period wrong");
  C_START: cover property (o_convert_start);
  C_STORE_IRQ: cover property (o_sample_stored ##1 o_irq);
  C_CLEAR: cover property (bw && i_addr == OFS_STATUS);
endmodule : adc_acquisition_control_props
bind adc_acquisition_control adc_acquisition_control_props props (.i_clock(i_clock), .i_nrst(i_nrst),
  .i_ce(i_ce), .i_addr(i_addr), .i_rd(i_rd), .i_wr(i_wr), .i_word(i_word), .i_wdata(i_wdata),
  .o_rdata(o_rdata), .o_digital_out_bit(o_digital_out_bit), .o_tick_1mhz(o_tick_1mhz),
  .o_counter_zero_clock_select(o_counter_zero_clock_select), .o_convert_start(o_convert_start),
  .o_sample_stored(o_sample_stored), .o_irq_level_select(o_irq_level_select), .o_irq(o_irq));

// ===== bench/adc_acquisition_control_tb_top.sv
`timescale 1ns/1ns
module adc_acquisition_control_tb_top;
  import adc_acq_pkg::*;
  logic i_clock = 1'b0;
  logic i_nrst = 1'b0;
  logic rd_s = 1'b0;
  logic wr_s = 1'b0;
  logic word = 1'b0;
  logic pace = 1'b0;
  logic slow = 1'b0;
  logic enh = 1'b0;
  logic ctc = 1'b0;
  logic uni = 1'b1;
  logic [3:0] addr = 4'h0;
  logic [15:0] wdata = 16'h0000;
  logic [3:0] din = 4'h0;
  logic [15:0] rdata, cres;
  logic [3:0] dout, lvl;
  logic [2:0] mux;
  logic cstart, cdone, stored, irq, csel;
  int miscompares = 0;
  int checks_done = 0;
  int nstore = 0;
  int n;
  adc_acquisition_control dut (.i_clock(i_clock), .i_nrst(i_nrst), .i_ce(1'b1), .i_addr(addr), .i_rd(rd_s),
    .i_wr(wr_s), .i_word(word), .i_wdata(wdata), .o_rdata(rdata), .i_digital_in_bit(din),
    .o_digital_out_bit(dout), .i_unipolar(uni), .i_enhanced(enh), .i_residual_gate(enh),
    .i_counter_zero_tc(ctc), .i_internal_pacer(pace), .o_counter_zero_gate(), .o_tick_1mhz(),
    .o_counter_zero_clock_select(csel), .o_pacer_gate(), .o_convert_start(cstart), .o_mux_channel(mux),
    .i_conv_done(cdone), .i_conv_result(cres), .o_sample_stored(stored), .o_irq_level_select(lvl), .o_irq(irq));
  adc_conv_model conv (.i_clock(i_clock), .i_start(cstart), .i_channel(mux), .i_slow(slow), .o_done(cdone),
    .o_result(cres));
  initial forever #4 i_clock = ~i_clock;
  // Samples are counted here so scenarios can wait on a total.
  always @(posedge i_clock) if (stored === 1'b1) nstore <= nstore + 1;
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : end_sim
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // Strobe is one cycle; the data word alone goes as a word.
  task automatic bus(input logic w, input logic [3:0] a, input logic [15:0] d);
    @(negedge i_clock);
    addr = a;
    word = (a == OFS_DATA);
    wdata = d;
    wr_s = w;
    rd_s = !w;
    @(negedge i_clock);
    wr_s = 1'b0;
    rd_s = 1'b0;
  endtask : bus
  task automatic rd(input logic [3:0] a, input logic [15:0] exp);
    bus(1'b0, a, 16'h0000);
    chk((a == OFS_DATA) ? rdata : {8'h00, rdata[7:0]}, exp);
  endtask : rd
  task automatic wait_n(input int target, input int lim);
    int k;
    for (k = 0; k < lim && nstore < target; k++) @(negedge i_clock);
    if (nstore < target) begin
      miscompares++;
      end_sim();
    end
  endtask : wait_n
  task automatic pulse_pacer();
    @(negedge i_clock);
    pace = 1'b1;
    @(negedge i_clock);
    pace = 1'b0;
    repeat (160) @(negedge i_clock);
  endtask : pulse_pacer
  // Residual mode takes its request from counter zero; also checks bipolar status.
  task automatic t_residual();
    enh = 1'b1;
    uni = 1'b0;
    bus(1'b1, OFS_STATUS, 16'h0000);
    chk({15'h0000, irq}, 16'h0000);
    @(negedge i_clock);
    ctc = 1'b1;
    @(negedge i_clock);
    ctc = 1'b0;
    chk({15'h0000, irq}, 16'h0001);
    bus(1'b1, OFS_STATUS, 16'h0000);
    chk({15'h0000, irq}, 16'h0000);
    rd(OFS_STATUS, 16'h0000);
    enh = 1'b0;
    uni = 1'b1;
  endtask : t_residual
  task automatic t_reset_scan_port();
    rd(OFS_SCAN, 16'h0000);
    rd(OFS_BURST, 16'h0000);
    rd(OFS_STATUS, 16'h0040);
    bus(1'b1, OFS_SCAN, 16'h0065);
    rd(OFS_SCAN, 16'h0065);
    rd(OFS_STATUS, 16'h0045);
    din = 4'ha;
    repeat (4) @(negedge i_clock);
    rd(OFS_PORT, {8'h00, BOARD_ID, 4'ha});
    bus(1'b1, OFS_PORT, 16'h00f3);
    chk({12'h000, dout}, 16'h0003);
  endtask : t_reset_scan_port
  task automatic t_levels();
    logic [3:0] c;
    for (int i = 0; i < 16; i++) begin
      c = 4'(i);
      bus(1'b1, OFS_IRQ_PACER, {8'h00, c, 4'h0});
      chk({12'h000, lvl}, (c inside {[2:7], 10, 11, 12, 14, 15}) ? {12'h000, c} : 16'h0000);
    end
    rd(OFS_IRQ_PACER, 16'h00f0);
  endtask : t_levels
  task automatic t_soft();
    bus(1'b1, OFS_IRQ_PACER, 16'h0050);
    n = nstore;
    bus(1'b1, OFS_DATA, 16'h0000);
    wait_n(n + 1, 3 * TICK_CYC + 30);
    repeat (2) @(negedge i_clock);
    chk({15'h0000, irq}, 16'h0001);
    rd(OFS_STATUS, 16'h0056);
    rd(OFS_DATA, 16'hc305);
    bus(1'b1, OFS_STATUS, 16'h0000);
    chk({15'h0000, irq}, 16'h0000);
  endtask : t_soft
  task automatic t_burst();
    bus(1'b1, OFS_SCAN, 16'h0020);
    bus(1'b1, OFS_BURST, 16'h0032);
    chk({15'h0000, csel}, 16'h0001);
    bus(1'b1, OFS_IRQ_PACER, 16'h0058);
    n = nstore;
    bus(1'b1, OFS_DATA, 16'h0000);
    wait_n(n + 3, 6 * TICK_CYC);
    repeat (2 * TICK_CYC) @(negedge i_clock);
    chk(16'(nstore - n), 16'h0003);
    rd(OFS_DATA, 16'hc300);
  endtask : t_burst
  task automatic t_paced();
    slow = 1'b1;
    bus(1'b1, OFS_BURST, 16'h0000);
    bus(1'b1, OFS_SCAN, 16'h0000);
    bus(1'b1, OFS_STATUS, 16'h0000);
    bus(1'b1, OFS_IRQ_PACER, 16'h0053);
    n = nstore;
    bus(1'b1, OFS_DATA, 16'h0000);
    repeat (511) pulse_pacer();
    chk({15'h0000, irq}, 16'h0000);
    chk(16'(nstore - n), 16'h01ff);
    pulse_pacer();
    chk({15'h0000, irq}, 16'h0001);
    bus(1'b1, OFS_IRQ_PACER, 16'h0053);
    n = nstore;
    pulse_pacer();
    chk(16'(nstore - n), 16'h0000);
  endtask : t_paced
  initial begin
    repeat (6) @(negedge i_clock);
    i_nrst = 1'b1;
    repeat (3) @(negedge i_clock);
    t_reset_scan_port();
    t_levels();
    t_soft();
    t_burst();
    t_paced();
    t_residual();
    end_sim();
  end
endmodule : adc_acquisition_control_tb_top

// ===== bench/adc_conv_model.sv
`timescale 1ns/1ns
module adc_conv_model (
  input wire logic i_clock, // Clock.
  input wire logic i_start, // Convert start.
  input wire logic [2:0] i_channel, // Channel.
  input wire logic i_slow, // Long conversions.
  output logic o_done, // Result ready.
  output logic [15:0] o_result // Result.
);
  int cnt = 0;
  logic [2:0] ch = 3'h0;
  logic [15:0] last = 16'h0000;
  initial o_done = 1'b0;
  // One result per start; the channel sits in the low bits so order errors show.
  always @(posedge i_clock) begin
    o_done <= 1'b0;
    if (i_start) begin
      cnt <= i_slow ? 20 : 2;
      ch <= i_channel;
    end else if (cnt > 1) cnt <= cnt - 1;
    else if (cnt == 1) begin
      cnt <= 0;
      last <= {8'hc3, 5'h00, ch};
      o_done <= 1'b1;
    end
  end
  // Outside the pulse the bus shows the complement, so a stale capture is caught.
  assign o_result = o_done ? last : ~last;
endmodule : adc_conv_model

// ===== design/adc_acq_pkg.sv
package adc_acq_pkg;
  localparam logic [3:0] OFS_DATA = 4'h0;
  localparam logic [3:0] OFS_SCAN = 4'h2;
  localparam logic [3:0] OFS_PORT = 4'h3;
  localparam logic [3:0] OFS_STATUS = 4'h8;
  localparam logic [3:0] OFS_IRQ_PACER = 4'h9;
  localparam logic [3:0] OFS_BURST = 4'ha;
  // Board identification nibble; the value is arbitrary.
  localparam logic [3:0] BOARD_ID = 4'h5;
  localparam logic [7:0] RST_SCAN = 8'h00;
  localparam logic [7:0] RST_IRQ_PACER = 8'h00;
  localparam logic [7:0] RST_BURST = 8'h00;
  localparam int FIFO_DEPTH = 1024;
  localparam int FIFO_AW = 10;
  localparam logic [FIFO_AW:0] FIFO_HALF = 11'h200;
  localparam int CLK_MHZ = 125;
  localparam int TICK_NS = 1000;
  localparam int TICK_CYC = TICK_NS * CLK_MHZ / 1000;
  localparam logic [6:0] TICK_LAST = 7'(TICK_CYC - 1);
  localparam logic [1:0] START_TICKS = 2'h3;
  localparam int BIT_POS_IRQ_LEVEL = 4;
  localparam int BIT_POS_BURST_EN = 3;
  localparam int BIT_POS_TS1 = 1;
  localparam int BIT_POS_TS0 = 0;
  typedef enum logic [1:0] {CV_IDLE, CV_WAIT, CV_CONVERT} conv_state_e;
endpackage : adc_acq_pkg

// ===== design/adc_acquisition_control.sv
`timescale 1ns/1ns
module adc_acquisition_control
  import adc_acq_pkg::*;
(
  input wire logic i_clock, // 125 MHz clock.
  input wire logic i_nrst, // Asynchronous reset, active low.
  input wire logic i_ce, // Clock enable; state frozen while low.
  input wire logic [3:0] i_addr, // Register offset from base.
  input wire logic i_rd, // Read strobe, one cycle.
  input wire logic i_wr, // Write strobe, one cycle.
  input wire logic i_word, // High for a 16-bit transfer.
  input wire logic [15:0] i_wdata, // Write data.
  output logic [15:0] o_rdata, // Read data, registered.
  input wire logic [3:0] i_digital_in_bit, // Digital input pins.
  output logic [3:0] o_digital_out_bit, // Latched digital outputs.
  input wire logic i_unipolar, // Range mode from gain logic.
  input wire logic i_enhanced, // Enhanced mode from gain logic.
  input wire logic i_residual_gate, // Residual gate from gain logic.
  input wire logic i_counter_zero_tc, // Counter zero terminal count pulse.
  input wire logic i_internal_pacer, // Internal pacer pulse, same clock.
  output logic o_counter_zero_gate, // Gate to counter zero.
  output logic o_counter_zero_clock_select, // 1 selects internal 1 MHz.
  output logic o_tick_1mhz, // 1 MHz tick pulse.
  output logic o_pacer_gate, // Gate for the pacer counters.
  output logic o_convert_start, // Converter start pulse.
  output logic [2:0] o_mux_channel, // Channel being converted.
  input wire logic i_conv_done, // Converter result ready pulse.
  input wire logic [15:0] i_conv_result, // Converter result.
  output logic o_sample_stored, // Pulse per FIFO write, for residual counting.
  output logic [3:0] o_irq_level_select, // Selected request line, zero if off.
  output logic o_irq // Interrupt request level.
);
  logic rst_meta_reg, rst_n;
  logic [3:0] din_meta_reg, din_reg, din_prev_reg;
  logic [7:0] scan_reg, irq_pacer_reg, burst_reg;
  logic [3:0] dout_reg;
  logic [3:0] next_channel_reg, burst_left_reg;
  logic fifo_overflow_flag_reg, irq_latched_flag_reg, ext_trig_latch_reg, armed_reg;
  logic [15:0] fifo_mem [0:FIFO_DEPTH-1];
  logic [FIFO_AW-1:0] wptr_reg, rptr_reg;
  logic [FIFO_AW:0] count_reg;
  logic [6:0] tick_cnt_reg;
  logic [1:0] tick_wait_reg;
  conv_state_e state_reg;
  logic [1:0] trigger_source;
  logic burst_enable, trigger_polarity, trigger_style, external_trigger_enable;
  logic wr_scan, wr_port, wr_status, wr_irq, wr_data, rd_data;
  logic start_lvl, start_edge, run_ok, pace_evt, fifo_push, fifo_pop, tick;

  // Reset release passes two flops so the release is clean to the clock.
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      rst_meta_reg <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n <= rst_meta_reg;
    end
  end

  // Pin inputs are synchronised; only the second and third stages feed logic.
  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      din_meta_reg <= 4'h0;
      din_reg <= 4'h0;
      din_prev_reg <= 4'h0;
    end else if (i_ce) begin
      din_meta_reg <= i_digital_in_bit;
      din_reg <= din_meta_reg;
      din_prev_reg <= din_reg;
    end
  end

  assign trigger_source = irq_pacer_reg[BIT_POS_TS1:BIT_POS_TS0];
  assign burst_enable = irq_pacer_reg[BIT_POS_BURST_EN];
  assign trigger_polarity = burst_reg[3];
  assign trigger_style = burst_reg[2];
  assign external_trigger_enable = burst_reg[0];
  // Byte strobes; the data word only answers a word transfer.
  assign wr_data = i_ce && i_wr && i_word && (i_addr == OFS_DATA);
  assign rd_data = i_ce && i_rd && i_word && (i_addr == OFS_DATA);
  assign wr_scan = i_ce && i_wr && !i_word && (i_addr == OFS_SCAN);
  assign wr_port = i_ce && i_wr && !i_word && (i_addr == OFS_PORT);
  assign wr_status = i_ce && i_wr && !i_word && (i_addr == OFS_STATUS);
  assign wr_irq = i_ce && i_wr && !i_word && (i_addr == OFS_IRQ_PACER);

  // Control registers; a write to the pacer register also disarms software pacing.
  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      scan_reg <= RST_SCAN;
      irq_pacer_reg <= RST_IRQ_PACER;
      burst_reg <= RST_BURST;
      dout_reg <= 4'h0;
    end else if (i_ce && i_wr && !i_word) begin
      if (i_addr == OFS_SCAN) scan_reg <= i_wdata[7:0];
      if (i_addr == OFS_IRQ_PACER) irq_pacer_reg <= i_wdata[7:0];
      if (i_addr == OFS_BURST) burst_reg <= i_wdata[7:0];
      if (i_addr == OFS_PORT) dout_reg <= i_wdata[3:0];
    end
  end

  // Start input level after polarity, and its active edge.
  assign start_lvl = din_reg[1] ^ trigger_polarity;
  assign start_edge = start_lvl && !(din_prev_reg[1] ^ trigger_polarity);

  // External start latch, cleared by a port write; the set wins.
  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      ext_trig_latch_reg <= 1'b0;
    end else if (i_ce) begin
      if (start_edge) ext_trig_latch_reg <= 1'b1;
      else if (wr_port) ext_trig_latch_reg <= 1'b0;
    end
  end

  // Pacing armed by a data write; a pacer register write disarms it.
  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      armed_reg <= 1'b0;
    end else if (i_ce) begin
      if (wr_irq) armed_reg <= 1'b0;
      else if (wr_data && trigger_source[1]) armed_reg <= 1'b1;
    end
  end

  // Pacing runs when armed by software or by the external start.
  // In gate style without a software arm the start input must stay active; removing it stops.
  always_comb begin
    if (!external_trigger_enable) run_ok = armed_reg;
    else if (trigger_style) run_ok = armed_reg || ext_trig_latch_reg;
    else run_ok = armed_reg || start_lvl;
  end
  assign o_pacer_gate = run_ok;

  // Pace event per source: external pacer rising edge or internal pacer.
  always_comb begin
    if (trigger_source == 2'b10) pace_evt = din_reg[0] && !din_prev_reg[0];
    else if (trigger_source == 2'b11) pace_evt = i_internal_pacer;
    else pace_evt = 1'b0;
    pace_evt = pace_evt && run_ok && trigger_source[1];
  end

  // Free running 1 MHz timebase.
  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      tick_cnt_reg <= 7'h00;
    end else if (i_ce) begin
      tick_cnt_reg <= (tick_cnt_reg == TICK_LAST) ? 7'h00 : tick_cnt_reg + 7'h01;
    end
  end
  assign tick = i_ce && (tick_cnt_reg == TICK_LAST);
  assign o_tick_1mhz = tick;

  // Conversion sequencer. A software trigger gates three 1 MHz ticks before the
  // start pulse, so the first conversion starts within 3 us. Bursts then run
  // one channel per tick until the burst length is used up.
  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= CV_IDLE;
      tick_wait_reg <= 2'h0;
      next_channel_reg <= 4'h0;
      burst_left_reg <= 4'h0;
    end else if (i_ce) begin
      if (wr_scan) begin
        state_reg <= CV_IDLE;
        next_channel_reg <= i_wdata[3:0];
      end else begin
        case (state_reg)
          CV_IDLE: begin
            if ((wr_data && !trigger_source[1]) || pace_evt) begin
              state_reg <= CV_WAIT;
              // A pace event starts on the next tick, so one conversion, or one burst if enabled, follows each edge.
              // Only the software trigger waits out the three-tick delay.
              tick_wait_reg <= pace_evt ? START_TICKS - 2'h1 : 2'h0;
              burst_left_reg <= burst_enable ? burst_reg[7:4] : 4'h1;
            end
          end
          CV_WAIT: begin
            if (tick) begin
              if (tick_wait_reg == START_TICKS - 2'h1) state_reg <= CV_CONVERT;
              else tick_wait_reg <= tick_wait_reg + 2'h1;
            end
          end
          CV_CONVERT: begin
            if (i_conv_done) begin
              next_channel_reg <= (next_channel_reg >= scan_reg[7:4]) ? {1'b0, scan_reg[2:0]}
                                  : next_channel_reg + 4'h1;
              if (burst_left_reg > 4'h1) begin
                burst_left_reg <= burst_left_reg - 4'h1;
                state_reg <= CV_WAIT;
                tick_wait_reg <= START_TICKS - 2'h1;
              end else begin
                state_reg <= CV_IDLE;
              end
            end
          end
          default: state_reg <= CV_IDLE;
        endcase
      end
    end
  end
  assign o_convert_start = (state_reg == CV_WAIT) && tick && (tick_wait_reg == START_TICKS - 2'h1);
  assign o_mux_channel = next_channel_reg[2:0];

  // Sample FIFO. A scan range write empties it.
  assign fifo_push = i_ce && (state_reg == CV_CONVERT) && i_conv_done && !wr_scan && (count_reg != 11'h400);
  assign fifo_pop = rd_data && (count_reg != 11'h000);
  always_ff @(posedge i_clock) begin
    if (fifo_push) fifo_mem[wptr_reg] <= i_conv_result;
  end
  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      wptr_reg <= '0;
      rptr_reg <= '0;
      count_reg <= '0;
    end else if (wr_scan) begin
      wptr_reg <= '0;
      rptr_reg <= '0;
      count_reg <= '0;
    end else if (i_ce) begin
      if (fifo_push) wptr_reg <= wptr_reg + 10'h001;
      if (fifo_pop) rptr_reg <= rptr_reg + 10'h001;
      count_reg <= count_reg + {10'h000, fifo_push} - {10'h000, fifo_pop};
    end
  end
  assign o_sample_stored = fifo_push;

  // Sticky overflow: set when full, cleared only by a scan range write.
  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      fifo_overflow_flag_reg <= 1'b0;
    end else if (i_ce) begin
      if (count_reg == 11'h400) fifo_overflow_flag_reg <= 1'b1;
      else if (wr_scan) fifo_overflow_flag_reg <= 1'b0;
    end
  end

  // Interrupt source depends on trigger source and residual mode.
  // The set wins over a status write in the same cycle.
  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      irq_latched_flag_reg <= 1'b0;
    end else if (i_ce) begin
      if (i_enhanced && i_residual_gate) begin
        if (i_counter_zero_tc) irq_latched_flag_reg <= 1'b1;
        else if (wr_status) irq_latched_flag_reg <= 1'b0;
      end else if (trigger_source[1] && fifo_push && count_reg == FIFO_HALF - 11'h001) begin
        irq_latched_flag_reg <= 1'b1;
      end else if (!trigger_source[1] && fifo_push) begin
        irq_latched_flag_reg <= 1'b1;
      end else if (wr_status) begin
        irq_latched_flag_reg <= 1'b0;
      end
    end
  end

  // Request line select; unavailable codes leave the request off.
  always_comb begin
    case (irq_pacer_reg[7:BIT_POS_IRQ_LEVEL])
      4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'ha, 4'hb, 4'hc, 4'he, 4'hf:
        o_irq_level_select = irq_pacer_reg[7:BIT_POS_IRQ_LEVEL];
      default: o_irq_level_select = 4'h0;
    endcase
  end
  assign o_irq = irq_latched_flag_reg && (o_irq_level_select != 4'h0);

  assign o_counter_zero_gate = din_reg[2];
  assign o_counter_zero_clock_select = burst_reg[1];
  assign o_digital_out_bit = dout_reg;

  // Registered read mux; unused offsets read zero.
  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      o_rdata <= 16'h0000;
    end else if (i_ce && i_rd) begin
      if (i_word) o_rdata <= (i_addr == OFS_DATA) ? fifo_mem[rptr_reg] : 16'h0000;
      else begin
        case (i_addr)
          OFS_SCAN: o_rdata <= {8'h00, scan_reg};
          OFS_PORT: o_rdata <= {8'h00, BOARD_ID, din_reg};
          OFS_STATUS: o_rdata <= {8'h00, state_reg != CV_IDLE, i_unipolar,
                                  fifo_overflow_flag_reg, irq_latched_flag_reg, next_channel_reg};
          OFS_IRQ_PACER: o_rdata <= {8'h00, irq_pacer_reg};
          OFS_BURST: o_rdata <= {8'h00, burst_reg};
          default: o_rdata <= 16'h0000;
        endcase
      end
    end
  end
endmodule : adc_acquisition_control
